// File: core/panel_pkg.sv
// Constants shared by the operator front-panel console
package panel_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 14;
  localparam int DISP_W = 16;
  localparam int MEMHI_W = 6;
  localparam int PORT_W = 5;
  localparam int PORT_LSB = 9;
  localparam int FLAG_W = 4;
  localparam int CTRL_N = 9;
  // Control switch positions in the edge detector vector
  localparam int C_PASS = 0;
  localparam int C_DOWN = 1;
  localparam int C_UP = 2;
  localparam int C_LOAD = 3;
  localparam int C_STEP = 4;
  localparam int C_STORE = 5;
  localparam int C_IRQ = 6;
  localparam int C_RESET = 7;
  localparam int C_HALT = 8;
  localparam logic [DATA_W-1:0] PASS_RST = 8'h00;
  localparam logic [DATA_W-1:0] PASS_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [DISP_W-1:0] DISP_RST = 16'h0000;
  typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_XFER} acc_state_t;
endpackage

// File: core/switch_edge.sv
// Rising-edge pulse generator for a bank of panel switches
`timescale 1ns/100ps
module switch_edge #(
  parameter int N = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Switch levels and pulses
  input wire logic [N-1:0] level,
  output logic [N-1:0] pulse
);
  logic [N-1:0] prev_r;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          prev_r[i] <= 1'b0;
        end else begin
          prev_r[i] <= level[i];
        end
      end
      assign pulse[i] = level[i] & ~prev_r[i];
    end
  endgenerate
endmodule

// File: core/front_panel_debug_console.sv
// Operator front-panel console: lamps, manual access, stepping, search
//
// Functional notes
// RULE1: CPU runs interrupt opcode from console switches
// RULE2: Interrupt switch requests cycle using low switches
// RULE3: Lamps show run, wait and halt
// RULE4: Bus-owned lamp during console access, wait/halt only
// RULE5: Lamps for pending access and interrupt
// RULE6: Cycle lamps decode fetch, memory, port cycles
// RULE7: Lamps for direct access, read, write, interrupt
// RULE8: Memory address on display bits 0-13
// RULE9: Port address on display bits 9-13
// RULE10: Register display shows data; flags on input
// RULE11: Memory address from high six, low eight
// RULE12: Port address from five high-bank bits
// RULE13: Switch-input mode feeds sense switches to inputs
// RULE14: Pass-count control loads low switches
// RULE15: Address load, step down, step up
// RULE16: Manual access only while processor waits; code also allows it while halted
// RULE17: Search stop forces wait, lights lamp
// RULE18: Manual wait switch holds processor waiting
// RULE19: Step releases one instruction or resumes
// RULE20: Store switch writes low switches to target
// RULE21: Halt auto-store writes low switches on halt
// RULE22: Reset switch zeroes program counter only
// RULE23: Pass counter counts matching fetches to zero
`timescale 1ns/100ps
module front_panel_debug_console (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Switch banks
  input wire logic [7:0] addrHighSw,
  input wire logic [7:0] addrLowSw,
  // Mode switches
  input wire logic senseMode,
  input wire logic portAccessMode,
  input wire logic memAccessMode,
  input wire logic searchWaitMode,
  input wire logic waitMode,
  // Control switches
  input wire logic loadPassSw,
  input wire logic address_step_down,
  input wire logic address_step_up,
  input wire logic addrLoadSw,
  input wire logic single_step_resume,
  input wire logic store_word_switch,
  input wire logic halt_auto_store,
  input wire logic irqSw,
  input wire logic resetSw,
  // Processor state and cycle type
  input wire logic cpuWaiting,
  input wire logic cpuHalted,
  input wire logic cpuFetch,
  input wire logic memory_read_cycle,
  input wire logic memory_write_cycle,
  input wire logic port_transfer_cycle,
  input wire logic cpuPortOut,
  input wire logic cpuIntCycle,
  input wire logic [13:0] cpuAddr,
  input wire logic [7:0] cpuData,
  input wire logic [3:0] cpuFlags,
  // Processor controls
  output logic cpuWaitReq,
  output logic cpuIntReq,
  output logic [7:0] irq_opcode_switches,
  output logic pcClear,
  // Data presented to input instructions
  input wire logic [7:0] portInData,
  output logic [7:0] cpuInData,
  // Console bus access
  output logic [13:0] dmaAddr,
  output logic [7:0] dmaWrData,
  output logic dmaMemRead,
  output logic dmaMemWrite,
  output logic dmaPortRead,
  output logic dmaPortWrite,
  input wire logic [7:0] dmaRdData,
  // Status lamps
  output logic runLamp,
  output logic waitLamp,
  output logic haltLamp,
  output logic busOwnLamp,
  output logic breakpoint_reached_lamp,
  output logic accessReqLamp,
  output logic intReqLamp,
  // Cycle lamps
  output logic fetchLamp,
  output logic memLamp,
  output logic portLamp,
  output logic direct_access_lamp,
  output logic readLamp,
  output logic writeLamp,
  output logic intLamp,
  // Displays
  output logic [15:0] addrDisp,
  output logic [7:0] dataDisp,
  output logic [7:0] regDisp
);
  localparam int DW = panel_pkg::DATA_W;
  localparam int AW = panel_pkg::ADDR_W;

  ////////////////////////////////////////////////////////////////////////
  // Switch edges

  logic [panel_pkg::CTRL_N-1:0] ctrlLevel;
  logic [panel_pkg::CTRL_N-1:0] ctrlPulse;
  logic fetchPrev_r;
  logic fetchStart;

  assign ctrlLevel = {cpuHalted & halt_auto_store, resetSw, irqSw,
                      store_word_switch, single_step_resume, addrLoadSw,
                      address_step_up, address_step_down, loadPassSw};

  switch_edge #(
    .N(panel_pkg::CTRL_N)
  ) u_edges (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(ctrlLevel),
    .pulse(ctrlPulse)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetchPrev_r <= 1'b0;
    end else begin
      fetchPrev_r <= cpuFetch;
    end
  end
  assign fetchStart = cpuFetch & ~fetchPrev_r;

  function automatic logic [AW-1:0] memAddrOf(input logic [7:0] hi,
                                              input logic [7:0] lo);
    memAddrOf = {hi[panel_pkg::MEMHI_W-1:0], lo};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Memory access register

  logic [AW-1:0] accAddr_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      accAddr_r <= panel_pkg::ADDR_RST;
    end else if (ctrlPulse[panel_pkg::C_LOAD]) begin
      accAddr_r <= memAddrOf(addrHighSw, addrLowSw); // [RULE15] [RULE11]
    end else if (ctrlPulse[panel_pkg::C_DOWN]) begin
      accAddr_r <= accAddr_r - panel_pkg::ADDR_ONE; // [RULE15]
    end else if (ctrlPulse[panel_pkg::C_UP]) begin
      accAddr_r <= accAddr_r + panel_pkg::ADDR_ONE; // [RULE15]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Search with pass counter

  logic [DW-1:0] passCnt_r;
  logic bpReached_r;
  logic searchHit;

  assign searchHit = searchWaitMode & fetchStart & ~bpReached_r &
                     (cpuAddr == accAddr_r);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      passCnt_r <= panel_pkg::PASS_RST;
    end else if (ctrlPulse[panel_pkg::C_PASS]) begin
      passCnt_r <= addrLowSw; // [RULE14]
    end else if (searchHit && passCnt_r != panel_pkg::PASS_RST) begin
      passCnt_r <= passCnt_r - panel_pkg::PASS_ONE; // [RULE23]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bpReached_r <= 1'b0;
    end else if (searchHit && passCnt_r <= panel_pkg::PASS_ONE) begin
      bpReached_r <= 1'b1; // [RULE23] [RULE17]
    end else if (ctrlPulse[panel_pkg::C_STEP] || !searchWaitMode) begin
      bpReached_r <= 1'b0; // [RULE19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait hold and single step

  logic holdWait;
  logic stepping_r;
  logic accBusy;

  assign holdWait = waitMode | bpReached_r; // [RULE18] [RULE17]

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stepping_r <= 1'b0;
    end else if (ctrlPulse[panel_pkg::C_STEP] && waitMode &&
                 cpuWaiting) begin
      stepping_r <= 1'b1; // [RULE19]
    end else if (fetchStart) begin
      stepping_r <= 1'b0; // [RULE19]
    end
  end

  assign cpuWaitReq = (holdWait & ~stepping_r) | accBusy;

  ////////////////////////////////////////////////////////////////////////
  // Manual access engine

  panel_pkg::acc_state_t accState_r;
  logic accPend_r;
  logic accWrite_r;
  logic accPort_r;
  logic accMode;
  logic accKick;
  logic accXfer;

  assign accMode = memAccessMode | portAccessMode;
  assign accKick = accMode & (ctrlPulse[panel_pkg::C_STORE] |
                   ctrlPulse[panel_pkg::C_HALT] |
                   ctrlPulse[panel_pkg::C_LOAD] |
                   ctrlPulse[panel_pkg::C_UP] |
                   ctrlPulse[panel_pkg::C_DOWN]);
  assign accXfer = (accState_r == panel_pkg::ACC_XFER);
  assign accBusy = accXfer;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      accState_r <= panel_pkg::ACC_IDLE;
    end else begin
      case (accState_r)
        panel_pkg::ACC_IDLE: begin
          if (accKick) begin
            accState_r <= panel_pkg::ACC_WAIT;
          end
        end
        panel_pkg::ACC_WAIT: begin
          if (cpuWaiting || cpuHalted) begin
            accState_r <= panel_pkg::ACC_XFER; // [RULE16] [RULE4]
          end else if (!accMode) begin
            accState_r <= panel_pkg::ACC_IDLE;
          end
        end
        panel_pkg::ACC_XFER: begin
          accState_r <= panel_pkg::ACC_IDLE;
        end
        default: begin
          accState_r <= panel_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      accWrite_r <= 1'b0;
      accPort_r <= 1'b0;
    end else if (accKick && accState_r == panel_pkg::ACC_IDLE) begin
      accWrite_r <= ctrlPulse[panel_pkg::C_STORE] |
                    ctrlPulse[panel_pkg::C_HALT]; // [RULE20] [RULE21]
      accPort_r <= portAccessMode & ~memAccessMode;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      accPend_r <= 1'b0;
    end else begin
      accPend_r <= (accState_r == panel_pkg::ACC_WAIT) |
                   (accKick & (accState_r == panel_pkg::ACC_IDLE));
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dmaAddr <= panel_pkg::ADDR_RST;
      dmaWrData <= panel_pkg::DATA_RST;
    end else if (accState_r == panel_pkg::ACC_WAIT) begin
      if (accPort_r) begin
        dmaAddr <= panel_pkg::ADDR_RST;
        dmaAddr[panel_pkg::PORT_LSB +: panel_pkg::PORT_W] <=
          addrHighSw[panel_pkg::PORT_W-1:0]; // [RULE12]
      end else begin
        dmaAddr <= accAddr_r; // [RULE11]
      end
      dmaWrData <= addrLowSw; // [RULE20] [RULE21]
    end
  end

  assign dmaMemRead = accXfer & ~accPort_r & ~accWrite_r;
  assign dmaMemWrite = accXfer & ~accPort_r & accWrite_r; // [RULE20]
  assign dmaPortRead = accXfer & accPort_r & ~accWrite_r;
  assign dmaPortWrite = accXfer & accPort_r & accWrite_r; // [RULE20]

  ////////////////////////////////////////////////////////////////////////
  // Interrupt, reset and input data

  logic intPend_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intPend_r <= 1'b0;
    end else if (ctrlPulse[panel_pkg::C_IRQ]) begin
      intPend_r <= 1'b1; // [RULE2]
    end else if (cpuIntCycle) begin
      intPend_r <= 1'b0;
    end
  end
  assign cpuIntReq = intPend_r; // [RULE2]

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_opcode_switches <= panel_pkg::DATA_RST;
      pcClear <= 1'b0;
      cpuInData <= panel_pkg::DATA_RST;
    end else begin
      irq_opcode_switches <= addrLowSw; // [RULE1]
      pcClear <= ctrlPulse[panel_pkg::C_RESET]; // [RULE22]
      cpuInData <= senseMode ? addrHighSw : portInData; // [RULE13]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lamps and displays

  logic memCyc;

  assign memCyc = cpuFetch | memory_read_cycle | memory_write_cycle;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      runLamp <= 1'b0;
      waitLamp <= 1'b0;
      haltLamp <= 1'b0;
      busOwnLamp <= 1'b0;
      breakpoint_reached_lamp <= 1'b0;
      accessReqLamp <= 1'b0;
      intReqLamp <= 1'b0;
    end else begin
      runLamp <= ~cpuWaiting & ~cpuHalted; // [RULE3]
      waitLamp <= cpuWaiting; // [RULE3]
      haltLamp <= cpuHalted; // [RULE3]
      busOwnLamp <= accXfer; // [RULE4]
      breakpoint_reached_lamp <= bpReached_r; // [RULE17]
      accessReqLamp <= accPend_r; // [RULE5]
      intReqLamp <= intPend_r; // [RULE5]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetchLamp <= 1'b0;
      memLamp <= 1'b0;
      portLamp <= 1'b0;
      direct_access_lamp <= 1'b0;
      readLamp <= 1'b0;
      writeLamp <= 1'b0;
      intLamp <= 1'b0;
    end else begin
      fetchLamp <= cpuFetch; // [RULE6]
      memLamp <= memory_read_cycle | memory_write_cycle |
                 (accXfer & ~accPort_r); // [RULE6]
      portLamp <= port_transfer_cycle | (accXfer & accPort_r); // [RULE6]
      direct_access_lamp <= accXfer; // [RULE7]
      readLamp <= memory_read_cycle | cpuFetch |
                  (port_transfer_cycle & ~cpuPortOut) |
                  (accXfer & ~accWrite_r); // [RULE7]
      writeLamp <= memory_write_cycle |
                   (port_transfer_cycle & cpuPortOut) |
                   (accXfer & accWrite_r); // [RULE7]
      intLamp <= cpuIntCycle; // [RULE7]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addrDisp <= panel_pkg::DISP_RST;
    end else if (accXfer) begin
      addrDisp <= {2'b00, dmaAddr}; // [RULE8] [RULE9]
    end else if (port_transfer_cycle) begin
      addrDisp <= panel_pkg::DISP_RST;
      addrDisp[panel_pkg::PORT_LSB +: panel_pkg::PORT_W] <=
        cpuAddr[panel_pkg::PORT_LSB +: panel_pkg::PORT_W]; // [RULE9]
    end else if (memCyc) begin
      addrDisp <= {2'b00, cpuAddr}; // [RULE8]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dataDisp <= panel_pkg::DATA_RST;
    end else if (accXfer) begin
      dataDisp <= accWrite_r ? dmaWrData : dmaRdData;
    end else if (memCyc || port_transfer_cycle) begin
      dataDisp <= cpuData;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regDisp <= panel_pkg::DATA_RST;
    end else if (port_transfer_cycle && !cpuPortOut) begin
      regDisp <= {4'h0, cpuFlags}; // [RULE10]
    end else if (!accXfer) begin
      regDisp <= cpuData; // [RULE10]
    end
  end
endmodule

// File: sim/cpu_model.sv
// Behavioural processor module on the far side of the console
`timescale 1ns/100ps
module cpu_model (
  // Clock, reset and console controls
  input wire logic sys_clk, resetn, cpuWaitReq, cpuIntReq, pcClear, haltCmd,
  input wire logic [13:0] dmaAddr,
  input wire logic [7:0] dmaWrData,
  input wire logic dmaMemRead, dmaMemWrite, dmaPortRead, dmaPortWrite,
  // Processor state and buses
  output logic cpuWaiting, cpuHalted, cpuFetch, cpuIntCycle,
  output logic memory_read_cycle, memory_write_cycle,
  output logic port_transfer_cycle, cpuPortOut,
  output logic [13:0] cpuAddr, pc,
  output logic [7:0] cpuData, dmaRdData, portOut,
  output logic [3:0] cpuFlags
);
  logic [1:0] ph_r;
  logic intCyc_r, idle_r, run;
  logic [7:0] mem_r [16];
  assign run = !cpuWaiting && !cpuHalted;
  assign cpuFetch = run && !ph_r[1];
  assign cpuIntCycle = run && intCyc_r;
  assign memory_read_cycle = run && ph_r == 2'h2 && !pc[0];
  assign memory_write_cycle = run && ph_r == 2'h2 && pc[0];
  assign port_transfer_cycle = run && ph_r == 2'h3;
  assign cpuPortOut = pc[0];
  // Released buses show a pattern that changes every cycle
  assign cpuAddr = !run ? {7{idle_r, !idle_r}} :
    port_transfer_cycle ? {pc[4:0], 9'h000} : pc;
  assign cpuData = run ? {pc[3:0], 2'h0, ph_r} : {4{idle_r, !idle_r}};
  assign cpuFlags = run ? pc[3:0] : {2{!idle_r, idle_r}};
  assign dmaRdData = dmaMemRead ? mem_r[dmaAddr[3:0]] :
    dmaPortRead ? portOut : {4{!idle_r, idle_r}};
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ph_r <= 2'h0;
      pc <= 14'h0000;
      cpuWaiting <= 1'b1;
      cpuHalted <= 1'b0;
      intCyc_r <= 1'b0;
      idle_r <= 1'b0;
    end else begin
      idle_r <= !idle_r;
      if (pcClear) begin
        pc <= 14'h0000;
        ph_r <= 2'h0;
        cpuHalted <= 1'b0;
        cpuWaiting <= 1'b1;
      end else if (!cpuHalted) begin
        if (!cpuWaiting) ph_r <= ph_r + 2'h1;
        if (!cpuWaiting && ph_r == 2'h3 && !intCyc_r)
          pc <= (pc + 14'h0001) & 14'h000f;
        if (cpuWaiting || ph_r == 2'h3) begin
          cpuHalted <= haltCmd;
          cpuWaiting <= !haltCmd && cpuWaitReq;
          intCyc_r <= cpuIntReq && !haltCmd && !cpuWaitReq;
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (dmaMemWrite) mem_r[dmaAddr[3:0]] <= dmaWrData;
    if (dmaPortWrite) portOut <= dmaWrData;
  end
endmodule

// File: sim/front_panel_debug_console_monitor.sv
// Concurrent checks on the front-panel console ports
`timescale 1ns/100ps
module front_panel_debug_console_monitor (
  input wire logic sys_clk, resetn, waitMode, irqSw, resetSw, senseMode,
  input wire logic [7:0] addrLowSw, addrHighSw, portInData,
  input wire logic cpuWaiting, cpuHalted, cpuFetch, cpuIntCycle,
  input wire logic cpuWaitReq, cpuIntReq, pcClear,
  input wire logic [7:0] irq_opcode_switches, cpuInData,
  input wire logic dmaMemRead, dmaMemWrite, dmaPortRead, dmaPortWrite,
  input wire logic waitLamp, haltLamp, busOwnLamp, fetchLamp, intLamp,
  input wire logic breakpoint_reached_lamp
);
  logic up1_r, up2_r, xfer;
  assign xfer = dmaMemRead | dmaMemWrite | dmaPortRead | dmaPortWrite;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      up1_r <= 1'b0;
      up2_r <= 1'b0;
    end else begin
      up1_r <= 1'b1;
      up2_r <= up1_r;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  chk_wait_hold_forced: assert property (
    waitMode && !$past(waitMode) |-> cpuWaitReq) else $error("wait not forced");
  chk_opcode_follows: assert property (
    up2_r |-> irq_opcode_switches == $past(addrLowSw))
    else $error("opcode port stale");
  chk_irq_request_set: assert property (
    $rose(irqSw) |-> ##[1:2] cpuIntReq) else $error("irq not requested");
  chk_irq_request_clear: assert property (
    (cpuIntCycle && !irqSw)[*3] |-> !cpuIntReq) else $error("irq not cleared");
  chk_state_lamps: assert property (
    up2_r |-> {waitLamp, haltLamp, fetchLamp, intLamp} ==
    $past({cpuWaiting, cpuHalted, cpuFetch, cpuIntCycle}))
    else $error("state lamp wrong");
  chk_sense_select: assert property (
    up2_r |-> cpuInData == $past(senseMode ? addrHighSw : portInData))
    else $error("input data wrong");
  chk_access_waits: assert property (
    xfer |-> $past(cpuWaiting || cpuHalted)) else $error("access while run");
  chk_strobe_single: assert property (
    xfer |=> !xfer) else $error("strobe too long");
  chk_bus_own_lamp: assert property (
    up2_r |-> busOwnLamp == $past(xfer)) else $error("bus lamp wrong");
  chk_reset_pulse: assert property (
    $rose(resetSw) |-> ##[1:2] pcClear ##1 !pcClear)
    else $error("pc clear pulse wrong");
  chk_break_waits: assert property (
    $rose(breakpoint_reached_lamp) |-> $past(cpuWaitReq) && cpuWaitReq)
    else $error("breakpoint not waiting");
  cover property (dmaMemWrite);
  cover property (dmaPortWrite);
  cover property ($rose(breakpoint_reached_lamp));
  cover property (cpuIntCycle && intLamp);
endmodule
bind front_panel_debug_console front_panel_debug_console_monitor u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .waitMode(waitMode), .irqSw(irqSw),
  .resetSw(resetSw), .senseMode(senseMode), .addrLowSw(addrLowSw),
  .addrHighSw(addrHighSw), .portInData(portInData), .cpuWaiting(cpuWaiting),
  .cpuHalted(cpuHalted), .cpuFetch(cpuFetch), .cpuIntCycle(cpuIntCycle),
  .cpuWaitReq(cpuWaitReq), .cpuIntReq(cpuIntReq), .pcClear(pcClear),
  .irq_opcode_switches(irq_opcode_switches), .cpuInData(cpuInData),
  .dmaMemRead(dmaMemRead), .dmaMemWrite(dmaMemWrite),
  .dmaPortRead(dmaPortRead), .dmaPortWrite(dmaPortWrite),
  .waitLamp(waitLamp), .haltLamp(haltLamp), .busOwnLamp(busOwnLamp),
  .fetchLamp(fetchLamp), .intLamp(intLamp),
  .breakpoint_reached_lamp(breakpoint_reached_lamp)
);

// File: sim/tb_front_panel_debug_console.sv
// Self-checking bench for the front-panel console
`timescale 1ns/100ps
module tb_front_panel_debug_console;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic senseMode = 1'b0;
  logic portAccessMode = 1'b0;
  logic memAccessMode = 1'b0;
  logic searchWaitMode = 1'b0;
  logic waitMode = 1'b0;
  logic haltCmd = 1'b0;
  logic [8:0] ctl = 9'h000;
  logic [7:0] addrHighSw = 8'h00;
  logic [7:0] addrLowSw = 8'h00;
  logic [7:0] portInData = 8'h00;
  logic cpuWaitReq, cpuIntReq, pcClear, fetchPrev;
  logic [7:0] cpuInData, dmaWrData, irq_opcode_switches, dmaRdData;
  logic [7:0] dataDisp, regDisp, cpuData, portOut;
  logic [13:0] dmaAddr, cpuAddr, pc, pcSeen;
  logic [15:0] addrDisp;
  logic [3:0] cpuFlags;
  logic cpuWaiting, cpuHalted, cpuFetch, memory_read_cycle;
  logic memory_write_cycle, port_transfer_cycle, cpuPortOut, cpuIntCycle;
  logic dmaMemRead, dmaMemWrite, dmaPortRead, dmaPortWrite;
  logic runLamp, waitLamp, haltLamp, busOwnLamp, breakpoint_reached_lamp;
  logic accessReqLamp, intReqLamp, fetchLamp, memLamp, portLamp;
  logic direct_access_lamp, readLamp, writeLamp, intLamp;
  int n_errors = 0;
  int checks_done = 0;
  int hits = 0;
  front_panel_debug_console u_dut (
    .sys_clk, .resetn, .addrHighSw, .addrLowSw, .senseMode, .portAccessMode,
    .memAccessMode, .searchWaitMode, .waitMode,
    .loadPassSw(ctl[panel_pkg::C_PASS]),
    .address_step_down(ctl[panel_pkg::C_DOWN]),
    .address_step_up(ctl[panel_pkg::C_UP]),
    .addrLoadSw(ctl[panel_pkg::C_LOAD]),
    .single_step_resume(ctl[panel_pkg::C_STEP]),
    .store_word_switch(ctl[panel_pkg::C_STORE]),
    .halt_auto_store(ctl[panel_pkg::C_HALT]), .irqSw(ctl[panel_pkg::C_IRQ]),
    .resetSw(ctl[panel_pkg::C_RESET]), .cpuWaiting, .cpuHalted, .cpuFetch,
    .memory_read_cycle, .memory_write_cycle, .port_transfer_cycle,
    .cpuPortOut, .cpuIntCycle, .cpuAddr, .cpuData, .cpuFlags, .cpuWaitReq,
    .cpuIntReq, .irq_opcode_switches, .pcClear, .portInData, .cpuInData,
    .dmaAddr, .dmaWrData, .dmaMemRead, .dmaMemWrite, .dmaPortRead,
    .dmaPortWrite, .dmaRdData, .runLamp, .waitLamp, .haltLamp, .busOwnLamp,
    .breakpoint_reached_lamp, .accessReqLamp, .intReqLamp, .fetchLamp,
    .memLamp, .portLamp, .direct_access_lamp, .readLamp, .writeLamp,
    .intLamp, .addrDisp, .dataDisp, .regDisp
  );
  cpu_model u_cpu (
    .sys_clk, .resetn, .cpuWaitReq, .cpuIntReq, .pcClear, .haltCmd, .dmaAddr,
    .dmaWrData, .dmaMemRead, .dmaMemWrite, .dmaPortRead, .dmaPortWrite,
    .cpuWaiting, .cpuHalted, .cpuFetch, .cpuIntCycle, .memory_read_cycle,
    .memory_write_cycle, .port_transfer_cycle, .cpuPortOut, .cpuAddr, .pc,
    .cpuData, .dmaRdData, .portOut, .cpuFlags
  );
  always #5 sys_clk = !sys_clk;
  // Fetches of the search address seen while searching
  always @(negedge sys_clk) begin
    if (searchWaitMode && cpuFetch && !fetchPrev && cpuAddr == 14'h0008)
      hits++;
    fetchPrev = cpuFetch;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic press(input int i);
    @(negedge sys_clk);
    ctl[i] = 1'b1;
    @(negedge sys_clk);
    ctl[i] = 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return cpuWaiting;
      1: return dmaMemRead;
      2: return dmaMemWrite;
      3: return dmaPortWrite;
      4: return breakpoint_reached_lamp;
      5: return cpuIntCycle;
      7: return dmaPortRead;
      default: return pcClear;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic lvl);
    int k;
    k = 0;
    while (pick(s) !== lvl && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 400) n_errors++;
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk);
    addrLowSw = 8'h3c;
    press(panel_pkg::C_IRQ);
    wait_for(5, 1'b1);
    check(irq_opcode_switches, 8'h3c);
    check(intReqLamp, 1'b1);
    wait_for(5, 1'b0);
    check(cpuIntReq, 1'b0);
    waitMode = 1'b1;
    wait_for(0, 1'b1);
    @(negedge sys_clk);
    check({runLamp, waitLamp, haltLamp}, 3'b010);
    pcSeen = pc;
    press(panel_pkg::C_STEP);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    check(pc, (pcSeen + 14'h0001) & 14'h000f);
    check(regDisp, pcSeen[0] ? {pcSeen[3:0], 4'h3} :
          {4'h0, pcSeen[3:0]});
    check(addrDisp, {2'h0, pcSeen[4:0], 9'h000});
    senseMode = 1'b1;
    addrHighSw = 8'h99;
    portInData = 8'h42;
    repeat (2) @(negedge sys_clk);
    check(cpuInData, 8'h99);
    senseMode = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(cpuInData, 8'h42);
    memAccessMode = 1'b1;
    addrHighSw = 8'hc2;
    addrLowSw = 8'h05;
    press(panel_pkg::C_LOAD);
    wait_for(1, 1'b1);
    check(dmaAddr, 14'h0205);
    addrLowSw = 8'ha7;
    press(panel_pkg::C_STORE);
    wait_for(2, 1'b1);
    check({accessReqLamp, dmaWrData}, 9'h1a7);
    @(negedge sys_clk);
    check({busOwnLamp, direct_access_lamp}, 2'h3);
    check({memLamp, writeLamp}, 2'h3);
    check(addrDisp, 16'h0205);
    press(panel_pkg::C_UP);
    wait_for(1, 1'b1);
    check(dmaAddr, 14'h0206);
    press(panel_pkg::C_DOWN);
    wait_for(1, 1'b1);
    check(dmaAddr, 14'h0205);
    @(negedge sys_clk);
    check({readLamp, dataDisp}, 9'h1a7);
    memAccessMode = 1'b0;
    portAccessMode = 1'b1;
    addrHighSw = 8'h13;
    addrLowSw = 8'h6e;
    press(panel_pkg::C_STORE);
    wait_for(3, 1'b1);
    check({dmaAddr[13:9], dmaWrData}, {5'h13, 8'h6e});
    @(negedge sys_clk);
    check({portLamp, writeLamp, addrDisp[13:9]}, 7'h73);
    check(portOut, 8'h6e);
    press(panel_pkg::C_UP);
    wait_for(7, 1'b1);
    @(negedge sys_clk);
    check({readLamp, writeLamp, portLamp, dataDisp}, 11'h56e);
    portAccessMode = 1'b0;
    addrLowSw = 8'h02;
    press(panel_pkg::C_PASS);
    addrHighSw = 8'h00;
    addrLowSw = 8'h08;
    press(panel_pkg::C_LOAD);
    searchWaitMode = 1'b1;
    waitMode = 1'b0;
    wait_for(4, 1'b1);
    check(hits[15:0], 16'h0002);
    wait_for(0, 1'b1);
    check(pc, 14'h0009);
    press(panel_pkg::C_STEP);
    wait_for(0, 1'b0);
    @(negedge sys_clk);
    check(breakpoint_reached_lamp, 1'b0);
    searchWaitMode = 1'b0;
    memAccessMode = 1'b1;
    ctl[panel_pkg::C_HALT] = 1'b1;
    addrLowSw = 8'h5d;
    haltCmd = 1'b1;
    wait_for(2, 1'b1);
    check(dmaAddr, 14'h0008);
    check(dmaWrData, 8'h5d);
    @(negedge sys_clk);
    check(haltLamp, 1'b1);
    haltCmd = 1'b0;
    press(panel_pkg::C_RESET);
    wait_for(6, 1'b1);
    @(negedge sys_clk);
    check({cpuHalted, pc}, 15'h0000);
    end_of_test();
  end
endmodule
